// ### design/ral_pkg.sv
// Purpose: Shared constants and types for the radiation alarm logic
// Assumes: 125 MHz system clock
// Notes: Register offsets are byte addresses on the plain register port

package ral_pkg;

	// Clock and times
	localparam longint unsigned CLK_HZ = 125_000_000;
	localparam longint unsigned NOCOUNT_TIME_S = 300;
	localparam longint unsigned NOCOUNT_CYC = NOCOUNT_TIME_S * CLK_HZ;
	localparam longint unsigned WDOG_TIME_MS = 1000;
	localparam longint unsigned WDOG_CYC = WDOG_TIME_MS * CLK_HZ / 1000;
	localparam longint unsigned DEBOUNCE_TIME_MS = 20;
	localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_TIME_MS * CLK_HZ / 1000;
	localparam longint unsigned FLASH_TIME_MS = 250;
	localparam longint unsigned FLASH_CYC = FLASH_TIME_MS * CLK_HZ / 1000;
	localparam int unsigned BOOT_CYC = 3;

	// Register map
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] ADDR_HIGH_SP = 5'h00;
	localparam logic [4:0] ADDR_WARN_SP = 5'h04;
	localparam logic [4:0] ADDR_UNDER_SP = 5'h08;
	localparam logic [4:0] ADDR_OVER_SP = 5'h0c;
	localparam logic [4:0] ADDR_DOSE = 5'h10;
	localparam logic [4:0] ADDR_CTRL = 5'h14;
	localparam logic [4:0] ADDR_STATUS = 5'h18;

	// Control fields
	localparam int unsigned CTRL_CHECK_SRC_BIT = 0;
	localparam int unsigned CTRL_WDOG_SVC_BIT = 1;

	// Status fields
	localparam int unsigned ST_HIGH_LSB = 0;
	localparam int unsigned ST_WARN_LSB = 2;
	localparam int unsigned ST_OVER_BIT = 4;
	localparam int unsigned ST_NOCOUNT_BIT = 5;
	localparam int unsigned ST_WDOG_BIT = 6;
	localparam int unsigned ST_ANTIJAM_BIT = 7;
	localparam int unsigned ST_UNDER_BIT = 8;
	localparam int unsigned ST_REJECT_BIT = 9;
	localparam int unsigned ST_JUMPER_LSB = 10;

	// Setpoint reset values
	localparam logic [15:0] HIGH_SP_RST = 16'h8000;
	localparam logic [15:0] WARN_SP_RST = 16'h4000;
	localparam logic [15:0] UNDER_SP_RST = 16'h0001;
	localparam logic [15:0] OVER_SP_RST = 16'hf000;

	localparam int unsigned AL_HIGH = 0;
	localparam int unsigned AL_WARN = 1;

	typedef enum logic [1:0] {
		AL_IDLE = 2'b00,
		AL_FLASH = 2'b01,
		AL_STEADY = 2'b10
	} ral_alarm_state_type;

	typedef enum logic [1:0] {
		BAR_GREEN = 2'b00,
		BAR_AMBER = 2'b01,
		BAR_RED = 2'b10
	} ral_bar_colour_type;

	typedef enum logic [1:0] {
		AO_LIVE = 2'b00,
		AO_ZERO = 2'b01,
		AO_FULL = 2'b10
	} ral_analog_mode_type;

	typedef enum logic [1:0] {
		DISP_LIVE = 2'b00,
		DISP_ZERO = 2'b01,
		DISP_ERROR = 2'b10
	} ral_disp_mode_type;

	typedef struct packed {
		logic reset_manual;
		logic nocount_en;
		logic cs_inhibit;
	} ral_jumper_type;

endpackage

// ### design/ral_alarm_logic.sv
// Purpose: Alarm annunciation for a digital ratemeter
// Assumes: Jumper pins read high when installed; buttons are raw pins
// Notes: Dose rate and setpoints arrive over the register port
//
// Implementation choices: strobed register access and the register addresses.

`timescale 1ns/100ps
`default_nettype none

module ral_alarm_logic
	import ral_pkg::*;
#(
	parameter int unsigned DOSE_W = 16,
	parameter longint unsigned NOCOUNT_CYCLES = NOCOUNT_CYC,
	parameter longint unsigned WDOG_CYCLES = WDOG_CYC,
	parameter longint unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
	parameter longint unsigned FLASH_CYCLES = FLASH_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Panel and detector pins
	input wire logic ack_btn_n,
	input wire logic enter_btn,
	input wire logic sp_disp_btn,
	input wire logic det_pulse,
	input wire logic antijam_pulse,
	input wire logic antijam_trip,
	// Configuration jumpers
	input wire logic reset_mode_jumper,
	input wire logic no_count_fail_enable_jumper,
	input wire logic check_source_alarm_inhibit_jumper,
	// Relay coils, high in bit 0, warn in bit 1
	output logic [1:0] alarm_coil,
	output logic fail_coil,
	// Indicators
	output logic [1:0] alarm_ind,
	output logic fail_ind,
	output logic range_ind,
	output logic units_ind,
	// Display, bargraph, analog and detector supply
	output ral_bar_colour_type bar_colour,
	output ral_analog_mode_type analog_mode,
	output ral_disp_mode_type disp_mode,
	output logic hv_enable
);

	localparam int unsigned NC_W = 36;
	localparam int unsigned CNT_W = 28;
	localparam int unsigned PIN_N = 9;

	generate
		if (DOSE_W < 1 || DOSE_W > 16)
			$error("DOSE_W must lie in 1..16");
		if (NOCOUNT_CYCLES < 2 || NOCOUNT_CYCLES >= (64'd1 << NC_W))
			$error("NOCOUNT_CYCLES out of range");
		if (WDOG_CYCLES < 2 || WDOG_CYCLES >= (64'd1 << CNT_W))
			$error("WDOG_CYCLES out of range");
		if (DEBOUNCE_CYCLES < 2 || DEBOUNCE_CYCLES >= (64'd1 << CNT_W))
			$error("DEBOUNCE_CYCLES out of range");
		if (FLASH_CYCLES < 2 || FLASH_CYCLES >= (64'd1 << CNT_W))
			$error("FLASH_CYCLES out of range");
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] pin_meta_reg;
	logic [PIN_N-1:0] pin_sync_reg;

	// Jumper order follows ral_jumper_type, reset mode in the top bit
	assign pin_raw = {reset_mode_jumper, no_count_fail_enable_jumper,
		check_source_alarm_inhibit_jumper, antijam_trip, antijam_pulse, det_pulse, sp_disp_btn,
		enter_btn, ~ack_btn_n};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	logic ack_s, enter_s, sp_disp_s, det_s, aj_pulse_s, aj_trip_s;
	ral_jumper_type jumper_s;

	assign ack_s = pin_sync_reg[0];
	assign enter_s = pin_sync_reg[1];
	assign sp_disp_s = pin_sync_reg[2];
	assign det_s = pin_sync_reg[3];
	assign aj_pulse_s = pin_sync_reg[4];
	assign aj_trip_s = pin_sync_reg[5];
	assign jumper_s = pin_sync_reg[8:6];

	////////////////////////////////////////////////////////////////////////
	// Jumper capture after reset release

	logic [1:0] boot_cnt_reg;
	logic jumpers_taken_reg;
	ral_jumper_type jumpers_reg;

	// Wait until the synchronisers hold real pin levels before sampling
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt_reg <= '0;
			jumpers_taken_reg <= 1'b0;
			jumpers_reg <= '0;
		end else if (!jumpers_taken_reg) begin
			boot_cnt_reg <= boot_cnt_reg + 2'(1);
			if (boot_cnt_reg == 2'(BOOT_CYC)) begin
				jumpers_taken_reg <= 1'b1;
				jumpers_reg <= jumper_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Acknowledge debounce

	logic [CNT_W-1:0] db_cnt_reg;
	logic ack_clean_reg;
	logic ack_evt_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			db_cnt_reg <= '0;
			ack_clean_reg <= 1'b0;
			ack_evt_reg <= 1'b0;
		end else begin
			ack_evt_reg <= 1'b0;
			if (ack_s == ack_clean_reg) begin
				db_cnt_reg <= '0;
			end else if (db_cnt_reg == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
				db_cnt_reg <= '0;
				ack_clean_reg <= ack_s;
				ack_evt_reg <= ack_s;
			end else begin
				db_cnt_reg <= db_cnt_reg + CNT_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [DOSE_W-1:0] high_sp_reg, warn_sp_reg, under_sp_reg, over_sp_reg;
	logic [DOSE_W-1:0] dose_reg;
	logic check_src_reg;
	logic sp_reject_reg;
	logic wdog_svc;
	logic [DOSE_W-1:0] wr_val;

	assign wr_val = reg_wdata[DOSE_W-1:0];
	assign wdog_svc = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_WDOG_SVC_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_sp_reg <= HIGH_SP_RST[DOSE_W-1:0];
			warn_sp_reg <= WARN_SP_RST[DOSE_W-1:0];
			under_sp_reg <= UNDER_SP_RST[DOSE_W-1:0];
			over_sp_reg <= OVER_SP_RST[DOSE_W-1:0];
			dose_reg <= '0;
			check_src_reg <= 1'b0;
			sp_reject_reg <= 1'b0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_HIGH_SP: begin
					sp_reject_reg <= wr_val < warn_sp_reg;
					if (wr_val >= warn_sp_reg)
						high_sp_reg <= wr_val;
				end
				ADDR_WARN_SP: begin
					sp_reject_reg <= wr_val > high_sp_reg;
					if (wr_val <= high_sp_reg)
						warn_sp_reg <= wr_val;
				end
				ADDR_UNDER_SP: under_sp_reg <= wr_val;
				ADDR_OVER_SP: over_sp_reg <= wr_val;
				ADDR_DOSE: dose_reg <= wr_val;
				ADDR_CTRL: check_src_reg <= reg_wdata[CTRL_CHECK_SRC_BIT];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Failure detection

	logic det_d_reg;
	logic [NC_W-1:0] nc_cnt_reg;
	logic nc_fail_reg;
	logic [CNT_W-1:0] wd_cnt_reg;
	logic wd_fail_reg;
	logic aj_latched_reg;
	logic fail_now;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			det_d_reg <= 1'b0;
			nc_cnt_reg <= '0;
			nc_fail_reg <= 1'b0;
		end else begin
			det_d_reg <= det_s;
			if (det_s && !det_d_reg)
				nc_cnt_reg <= '0;
			else if (nc_cnt_reg != NC_W'(NOCOUNT_CYCLES - 1))
				nc_cnt_reg <= nc_cnt_reg + NC_W'(1);
			nc_fail_reg <= jumpers_reg.nocount_en && !(det_s && !det_d_reg) &&
				nc_cnt_reg == NC_W'(NOCOUNT_CYCLES - 1);
		end
	end

	// Servicing restarts the timer, so the fail clears by itself
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_reg <= '0;
			wd_fail_reg <= 1'b0;
		end else begin
			if (wdog_svc)
				wd_cnt_reg <= '0;
			else if (wd_cnt_reg != CNT_W'(WDOG_CYCLES - 1))
				wd_cnt_reg <= wd_cnt_reg + CNT_W'(1);
			wd_fail_reg <= !wdog_svc && wd_cnt_reg == CNT_W'(WDOG_CYCLES - 1);
		end
	end

	// Only a reset clears the trip, standing in for the power cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			aj_latched_reg <= 1'b0;
		else if (aj_trip_s)
			aj_latched_reg <= 1'b1;
	end

	assign fail_now = nc_fail_reg || wd_fail_reg || aj_latched_reg;

	////////////////////////////////////////////////////////////////////////
	// Range conditions

	logic under_cond, over_cond;
	logic over_alarm_reg;
	logic enter_d_reg;
	logic units_reg;

	assign under_cond = dose_reg < under_sp_reg;
	assign over_cond = dose_reg >= over_sp_reg || aj_pulse_s;

	// Set wins over the acknowledge clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			over_alarm_reg <= 1'b0;
		else if (over_cond)
			over_alarm_reg <= 1'b1;
		else if (ack_evt_reg)
			over_alarm_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enter_d_reg <= 1'b0;
			units_reg <= 1'b0;
		end else begin
			enter_d_reg <= enter_s;
			if (over_alarm_reg && sp_disp_s)
				units_reg <= 1'b1;
			else if (enter_s && !enter_d_reg)
				units_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// High and warn alarm machines

	ral_alarm_state_type al_state [2];
	logic [DOSE_W-1:0] al_sp [2];
	logic [1:0] al_cond;
	logic al_inhibit;

	assign al_sp[AL_HIGH] = high_sp_reg;
	assign al_sp[AL_WARN] = warn_sp_reg;
	assign al_inhibit = !jumpers_taken_reg || (check_src_reg && jumpers_reg.cs_inhibit);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_alarm
			assign al_cond[gi] = dose_reg >= al_sp[gi] || over_alarm_reg;

			// Frozen while inhibited, so an existing alarm is held
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					al_state[gi] <= AL_IDLE;
				end else if (!al_inhibit) begin
					unique case (al_state[gi])
						AL_IDLE: begin
							if (al_cond[gi])
								al_state[gi] <= jumpers_reg.reset_manual ? AL_FLASH : AL_STEADY;
						end
						AL_FLASH: begin
							if (ack_evt_reg)
								al_state[gi] <= al_cond[gi] ? AL_STEADY : AL_IDLE;
						end
						AL_STEADY: begin
							if (!al_cond[gi])
								al_state[gi] <= AL_IDLE;
						end
						default: al_state[gi] <= AL_IDLE;
					endcase
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Flash timebase

	logic [CNT_W-1:0] flash_cnt_reg;
	logic flash_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_cnt_reg <= '0;
			flash_reg <= 1'b0;
		end else if (flash_cnt_reg == CNT_W'(FLASH_CYCLES - 1)) begin
			flash_cnt_reg <= '0;
			flash_reg <= ~flash_reg;
		end else begin
			flash_cnt_reg <= flash_cnt_reg + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output stage

	logic [1:0] alarm_coil_reg, alarm_ind_reg;
	logic fail_coil_reg, fail_ind_reg, range_ind_reg, hv_enable_reg;
	ral_bar_colour_type bar_colour_reg;
	ral_analog_mode_type analog_mode_reg;
	ral_disp_mode_type disp_mode_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_coil_reg <= 2'b11;
			alarm_ind_reg <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				alarm_coil_reg[i] <= al_state[i] == AL_IDLE;
				alarm_ind_reg[i] <= al_state[i] == AL_STEADY ||
					(al_state[i] == AL_FLASH && flash_reg);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fail_coil_reg <= 1'b1;
			fail_ind_reg <= 1'b0;
			hv_enable_reg <= 1'b1;
		end else begin
			fail_coil_reg <= !fail_now;
			fail_ind_reg <= fail_now;
			hv_enable_reg <= !aj_latched_reg;
		end
	end

	// Check source also pulls the analog output to its low scale, except while an overrange alarm holds it at full scale
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			range_ind_reg <= 1'b0;
			bar_colour_reg <= BAR_GREEN;
			analog_mode_reg <= AO_LIVE;
			disp_mode_reg <= DISP_LIVE;
		end else begin
			range_ind_reg <= under_cond || over_alarm_reg;
			if (over_alarm_reg || al_state[AL_HIGH] != AL_IDLE)
				bar_colour_reg <= BAR_RED;
			else if (al_state[AL_WARN] != AL_IDLE)
				bar_colour_reg <= BAR_AMBER;
			else
				bar_colour_reg <= BAR_GREEN;
			if (over_alarm_reg) begin
				analog_mode_reg <= AO_FULL;
				disp_mode_reg <= DISP_ERROR;
			end else if (under_cond) begin
				analog_mode_reg <= AO_ZERO;
				disp_mode_reg <= DISP_ZERO;
			end else begin
				analog_mode_reg <= check_src_reg ? AO_ZERO : AO_LIVE;
				disp_mode_reg <= DISP_LIVE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port

	logic [31:0] status_word, rd_val;
	logic [31:0] rdata_reg;

	always_comb begin
		status_word = '0;
		status_word[ST_HIGH_LSB +: 2] = al_state[AL_HIGH];
		status_word[ST_WARN_LSB +: 2] = al_state[AL_WARN];
		status_word[ST_OVER_BIT] = over_alarm_reg;
		status_word[ST_NOCOUNT_BIT] = nc_fail_reg;
		status_word[ST_WDOG_BIT] = wd_fail_reg;
		status_word[ST_ANTIJAM_BIT] = aj_latched_reg;
		status_word[ST_UNDER_BIT] = under_cond;
		status_word[ST_REJECT_BIT] = sp_reject_reg;
		status_word[ST_JUMPER_LSB +: 3] = jumpers_reg;
	end

	always_comb begin
		unique case (reg_addr)
			ADDR_HIGH_SP: rd_val = 32'(high_sp_reg);
			ADDR_WARN_SP: rd_val = 32'(warn_sp_reg);
			ADDR_UNDER_SP: rd_val = 32'(under_sp_reg);
			ADDR_OVER_SP: rd_val = 32'(over_sp_reg);
			ADDR_DOSE: rd_val = 32'(dose_reg);
			ADDR_CTRL: rd_val = 32'(check_src_reg);
			ADDR_STATUS: rd_val = status_word;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rdata_reg <= 32'h0000_0000;
		else
			rdata_reg <= reg_rd ? rd_val : 32'h0000_0000;
	end

	assign reg_rdata = rdata_reg;
	assign alarm_coil = alarm_coil_reg;
	assign alarm_ind = alarm_ind_reg;
	assign fail_coil = fail_coil_reg;
	assign fail_ind = fail_ind_reg;
	assign range_ind = range_ind_reg;
	assign units_ind = units_reg;
	assign bar_colour = bar_colour_reg;
	assign analog_mode = analog_mode_reg;
	assign disp_mode = disp_mode_reg;
	assign hv_enable = hv_enable_reg;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	a_high_trip_fsm: assert property (@(posedge clk) disable iff (!rst_n)
		(!al_inhibit && al_state[AL_HIGH] == AL_IDLE && al_cond[AL_HIGH]) |=>
		al_state[AL_HIGH] != AL_IDLE)
		else $error("high alarm failed to trip");

	a_auto_steady: assert property (@(posedge clk) disable iff (!rst_n)
		!jumpers_reg.reset_manual |-> al_state[AL_WARN] != AL_FLASH)
		else $error("auto reset alarm flashed");

	a_coil_follow: assert property (@(posedge clk) disable iff (!rst_n)
		(al_state[AL_HIGH] != AL_IDLE) |=> !alarm_coil[AL_HIGH] && bar_colour == BAR_RED)
		else $error("high coil energized while alarmed");

	a_inhibit_hold: assert property (@(posedge clk) disable iff (!rst_n)
		al_inhibit |=> $stable(al_state[AL_WARN]) && $stable(al_state[AL_HIGH]))
		else $error("alarm moved while inhibited");

	a_over_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(over_alarm_reg && !ack_evt_reg) |=> over_alarm_reg)
		else $error("overrange cleared without acknowledge");

	a_nocount_gate: assert property (@(posedge clk) disable iff (!rst_n)
		nc_fail_reg |-> jumpers_reg.nocount_en)
		else $error("no-count fail while disabled");

	a_antijam_hv: assert property (@(posedge clk) disable iff (!rst_n)
		aj_latched_reg |=> !hv_enable && fail_ind ##1 !hv_enable && !fail_coil)
		else $error("anti-jam trip left supply on");

	a_sp_reject: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == ADDR_HIGH_SP && wr_val < warn_sp_reg) |=>
		$stable(high_sp_reg) && sp_reject_reg)
		else $error("bad high setpoint accepted");

	a_range_lamp: assert property (@(posedge clk) disable iff (!rst_n)
		over_alarm_reg |=> range_ind && disp_mode == DISP_ERROR && analog_mode == AO_FULL)
		else $error("overrange outputs wrong");

	a_ack_single: assert property (@(posedge clk) disable iff (!rst_n)
		ack_evt_reg |=> !ack_evt_reg [*2])
		else $error("acknowledge repeated");

	a_jumper_frozen: assert property (@(posedge clk) disable iff (!rst_n)
		jumpers_taken_reg |=> $stable(jumpers_reg))
		else $error("jumpers changed after power-up");

endmodule

`default_nettype wire

// ### sim/ral_panel_model.sv
// Purpose: Panel and detector stand-in for the alarm logic
// Assumes: Bench sets button and pulse enables at clock edges
// Notes: Relays and lamps are read by the bench directly
`timescale 1ns/100ps
`default_nettype none
module ral_panel_model (
	// Clock
	input wire logic clk,
	// Bench controls
	input wire logic pulse_en,
	input wire logic ack_press,
	// Pins toward the block
	output logic ack_btn_n,
	output logic det_pulse
);
	logic btn_reg = 1'b1;
	logic det_reg = 1'b0;
	logic [2:0] div_reg = 3'h0;
	assign ack_btn_n = btn_reg;
	assign det_pulse = det_reg;
	// Button is pulled up while released; detector line idles low between counts
	always @(posedge clk) begin
		btn_reg <= ~ack_press;
		div_reg <= div_reg + 3'h1;
		det_reg <= pulse_en && (div_reg == 3'h0);
	end
endmodule
`default_nettype wire

// ### sim/ral_alarm_logic_tb_top.sv
// Purpose: Self-checking bench for the alarm logic
// Assumes: Shortened no-count, watchdog, debounce and flash counts
// Notes: Each scenario is one task
`timescale 1ns/100ps
`default_nettype none
module ral_alarm_logic_tb_top;
	import ral_pkg::*;
	logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, enter_btn = 0, sp_disp_btn = 0, antijam_pulse = 0;
	logic antijam_trip = 0, jp_man = 1, jp_nc = 1, jp_cs = 1, pulse_en = 1, ack_press = 0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd_val;
	logic [1:0] alarm_coil, alarm_ind;
	logic fail_coil, fail_ind, range_ind, units_ind, hv_enable, ack_btn_n, det_pulse;
	ral_bar_colour_type bar_colour;
	ral_analog_mode_type analog_mode;
	ral_disp_mode_type disp_mode;
	int miscompares = 0, comparisons = 0, flips;
	always #4 clk = ~clk;
	ral_alarm_logic #(.NOCOUNT_CYCLES(200), .WDOG_CYCLES(100), .DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8))
	ral_alarm_logic_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ack_btn_n(ack_btn_n), .enter_btn(enter_btn),
		.sp_disp_btn(sp_disp_btn), .det_pulse(det_pulse), .antijam_pulse(antijam_pulse),
		.antijam_trip(antijam_trip), .reset_mode_jumper(jp_man), .no_count_fail_enable_jumper(jp_nc),
		.check_source_alarm_inhibit_jumper(jp_cs), .alarm_coil(alarm_coil), .fail_coil(fail_coil),
		.alarm_ind(alarm_ind), .fail_ind(fail_ind), .range_ind(range_ind), .units_ind(units_ind),
		.bar_colour(bar_colour), .analog_mode(analog_mode), .disp_mode(disp_mode), .hv_enable(hv_enable));
	ral_panel_model ral_panel_model_i (.clk(clk), .pulse_en(pulse_en), .ack_press(ack_press),
		.ack_btn_n(ack_btn_n), .det_pulse(det_pulse));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	// Press long enough to pass sync and debounce, then release just as long
	task automatic ack;
		@(posedge clk);
		ack_press <= 1'b1;
		cyc(12);
		@(posedge clk);
		ack_press <= 1'b0;
		cyc(12);
	endtask
	task automatic count_flash;
		logic p;
		flips = 0;
		p = alarm_ind[0];
		repeat (24) begin
			cyc(1);
			if (alarm_ind[0] !== p) flips++;
			p = alarm_ind[0];
		end
	endtask
	task automatic do_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		cyc(18);
		chk(32'({alarm_coil, fail_coil, hv_enable, bar_colour}), 32'h0000_003c);
		@(posedge clk);
		rst_n <= 1'b1;
		cyc(8);
	endtask
	task automatic results;
		if (miscompares == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_setpoints;
		rd(5'h1c);
		chk(rd_val, 32'h0000_0000);
		wr(ADDR_HIGH_SP, 32'h0000_3000);
		rd(ADDR_HIGH_SP);
		chk(rd_val, 32'h0000_8000);
		rd(ADDR_STATUS);
		chk(32'({rd_val[12:10], rd_val[9]}), 32'h0000_000f);
		wr(ADDR_WARN_SP, 32'h0000_4000);
		rd(ADDR_STATUS);
		chk(32'(rd_val[9]), 32'h0000_0000);
	endtask
	task automatic t_manual;
		wr(ADDR_DOSE, 32'h0000_3fff);
		cyc(6);
		chk(32'(alarm_coil), 32'h0000_0003);
		wr(ADDR_DOSE, 32'h0000_4000);
		cyc(6);
		chk(32'({alarm_coil, bar_colour}), 32'h0000_0005);
		wr(ADDR_DOSE, 32'h0000_8000);
		cyc(6);
		chk(32'({alarm_coil, bar_colour}), 32'h0000_0002);
		count_flash();
		chk(32'(flips > 0), 32'h0000_0001);
		ack();
		count_flash();
		chk(32'({flips > 0, alarm_ind, alarm_coil}), 32'h0000_000c);
		wr(ADDR_DOSE, 32'h0000_0100);
		cyc(6);
		chk(32'({alarm_ind, alarm_coil, bar_colour}), 32'h0000_000c);
	endtask
	task automatic t_range;
		wr(ADDR_DOSE, 32'h0000_0000);
		cyc(6);
		chk(32'({range_ind, analog_mode, disp_mode, alarm_coil}), 32'h0000_0057);
		sp_disp_btn <= 1'b1;
		wr(ADDR_DOSE, 32'h0000_f000);
		cyc(6);
		chk(32'({range_ind, analog_mode, disp_mode, bar_colour, alarm_coil}), 32'h0000_01a8);
		chk(32'(units_ind), 32'h0000_0001);
		@(posedge clk);
		sp_disp_btn <= 1'b0;
		enter_btn <= 1'b1;
		cyc(4);
		@(posedge clk);
		enter_btn <= 1'b0;
		cyc(4);
		chk(32'(units_ind), 32'h0000_0000);
		ack();
		wr(ADDR_DOSE, 32'h0000_0100);
		cyc(40);
		chk(32'({range_ind, disp_mode}), 32'h0000_0006);
		ack();
		cyc(6);
		chk(32'({range_ind, disp_mode, alarm_coil}), 32'h0000_0003);
		antijam_pulse <= 1'b1;
		cyc(4);
		antijam_pulse <= 1'b0;
		cyc(6);
		chk(32'({range_ind, disp_mode, bar_colour}), 32'h0000_001a);
		ack();
		cyc(6);
		chk(32'({range_ind, alarm_coil}), 32'h0000_0003);
	endtask
	task automatic t_fail;
		wr(ADDR_CTRL, 32'h0000_0002);
		cyc(3);
		chk(32'({fail_ind, fail_coil}), 32'h0000_0001);
		cyc(110);
		chk(32'({fail_ind, fail_coil}), 32'h0000_0002);
		wr(ADDR_CTRL, 32'h0000_0002);
		cyc(3);
		chk(32'({fail_ind, fail_coil}), 32'h0000_0001);
		pulse_en <= 1'b0;
		repeat (3) begin
			cyc(80);
			wr(ADDR_CTRL, 32'h0000_0002);
		end
		rd(ADDR_STATUS);
		chk(32'({rd_val[5], fail_coil}), 32'h0000_0002);
		pulse_en <= 1'b1;
		cyc(20);
		wr(ADDR_CTRL, 32'h0000_0002);
		cyc(3);
		chk(32'(fail_coil), 32'h0000_0001);
		antijam_trip <= 1'b1;
		cyc(4);
		antijam_trip <= 1'b0;
		cyc(6);
		chk(32'({hv_enable, fail_coil, fail_ind}), 32'h0000_0001);
	endtask
	// Second power-up: auto reset, no-count off, inhibit in
	task automatic t_auto;
		jp_man <= 1'b0;
		jp_nc <= 1'b0;
		pulse_en <= 1'b0;
		do_reset();
		jp_man <= 1'b1;
		wr(ADDR_DOSE, 32'h0000_8000);
		cyc(6);
		count_flash();
		chk(32'({flips > 0, alarm_ind, alarm_coil}), 32'h0000_000c);
		wr(ADDR_DOSE, 32'h0000_0100);
		cyc(6);
		chk(32'({alarm_ind, alarm_coil}), 32'h0000_0003);
		repeat (3) begin
			cyc(80);
			wr(ADDR_CTRL, 32'h0000_0002);
		end
		rd(ADDR_STATUS);
		chk(32'(rd_val[5]), 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0003);
		wr(ADDR_DOSE, 32'h0000_8000);
		cyc(6);
		chk(32'(alarm_coil), 32'h0000_0003);
		wr(ADDR_CTRL, 32'h0000_0002);
		cyc(6);
		chk(32'(alarm_coil), 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0003);
		wr(ADDR_DOSE, 32'h0000_0100);
		cyc(6);
		chk(32'(alarm_coil), 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0002);
		cyc(6);
		chk(32'(alarm_coil), 32'h0000_0003);
		// Third power-up with the inhibit jumper removed: alarms live in check source
		jp_cs <= 1'b0;
		do_reset();
		wr(ADDR_CTRL, 32'h0000_0003);
		wr(ADDR_DOSE, 32'h0000_8000);
		cyc(6);
		chk(32'(alarm_coil), 32'h0000_0000);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		t_setpoints();
		t_manual();
		t_range();
		t_fail();
		t_auto();
		results();
	end
endmodule
`default_nettype wire
